//--- src/core_cmd_pkg.sv
package core_cmd_pkg;

  // register byte offsets (low address byte; upper address bits must be zero)
  localparam logic [7:0] OFS_COMMAND = 8'h00;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
  localparam logic [7:0] OFS_ADDR_LOW = 8'h08;
  localparam logic [7:0] OFS_HOLDER = 8'h0c;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // file registers sit at offset 0x40 + 4*index (FILE_WINDOW in bits 7:6), index 0..15
  localparam logic [1:0] FILE_WINDOW = 2'h1;

  // field positions in the flags and status words
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_COND_LSB = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_CNT_LSB = 1;
  localparam int STAT_WRITE = 4;
  localparam int STAT_HALF = 5;
  localparam int STAT_DMA = 6;

  // cycle timing, counted in clocks after the command clock
  localparam logic [2:0] FULL_LAST = 3'h4;
  localparam logic [2:0] HALF_LAST = 3'h2;
  localparam logic [2:0] LOAD_CNT = 3'h2;
  localparam logic [2:0] CNT_IDLE = 3'h0;
  localparam logic [2:0] CNT_FIRST = 3'h1;

  // reset values and the all-ones fill byte
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [7:0] ALL_ONES = 8'hff;

  typedef enum logic [1:0] {
    MODE_PASS = 2'b00,
    MODE_DEC = 2'b01,
    MODE_LINK = 2'b10,
    MODE_INC = 2'b11
  } route_mode_t;

  typedef enum logic [1:0] {
    DEST_NONE = 2'b00,
    DEST_HIGH = 2'b01,
    DEST_LOW = 2'b10,
    DEST_HOLDER = 2'b11
  } dest_t;

  typedef struct packed {
    logic [3:0] opcode;
    logic [3:0] file;
    route_mode_t mode;
    logic half;
    logic write;
    logic inhibit;
    logic spare;
    dest_t dest;
  } cmd_t;

  typedef struct packed {
    logic [7:0] offset;
    logic upper_zero;
    logic write;
  } bus_req_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_DATA = 1'b1
  } bus_state_t;

endpackage

//--- src/core_cmd_exec.sv
`timescale 1ns/10ps
// Function
// RULE1: command starts a core cycle moving one byte between holder and core at high:low address
// RULE2: microprogram never names file zero as source of a memory command
// RULE3: command bit 5 set gives half cycle, clear gives full cycle
// RULE4: command bit 4 set gives write, clear gives read
// RULE5: full cycle lasts five clocks, half cycle three clocks
// RULE6: full read restores core; full write clears first, stores new byte
// RULE7: half read leaves all ones; half write stores written byte AND old contents
// RULE8: bits 7:6 route file value unaltered, minus one, plus carry, plus one
// RULE9: decrement into address high with carry set passes value undecremented
// RULE10: add-link mode adds carry flag to file value and routes sum
// RULE11: read clears holder at command; fetched byte valid on second clock after (with dest DEST_HOLDER the code loads the routed value instead)
// RULE12: write data in holder by command (half) or first clock after (full)
// RULE13: write data held until four clocks after (full) or two (half)
// RULE14: memory command leaves condition flags and carry flag unchanged
// RULE15: new memory command waits while memory busy from earlier cycle or dma
// RULE16: address register change during active cycle stalls until cycle ends
// RULE17: holder access during read cycle stalls until fetched byte loaded
// RULE18: microprogram must not change holder during write hold window
// RULE19: both address registers hold target on or before command clock
// RULE20: from fifth clock after full command, address and holder change freely
// RULE21: stalled access leaves all register, file and sequencing state unchanged
module core_cmd_exec
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic dma_busy,
  output logic mem_busy
);
  import core_cmd_pkg::*;

  // bus slave state
  bus_state_t bus_state, next_bus_state;
  bus_req_t req, next_req;
  logic next_hreadyout;
  logic [31:0] next_hrdata;
  // processor-visible registers
  logic [7:0] addr_high, addr_low, holder, next_addr_high, next_addr_low, next_holder;
  logic carry_flag, next_carry_flag, file_we;
  logic [2:0] cond_flags, next_cond_flags;
  logic [7:0] files [0:15];
  logic [3:0] file_idx;
  logic [7:0] file_wdata;
  // memory cycle sequencing
  logic [2:0] cnt, next_cnt, last_cnt;
  logic cyc_write, cyc_half, next_cyc_write, next_cyc_half, next_mem_busy;
  logic [15:0] cyc_addr, next_cyc_addr;
  // core array
  logic [7:0] core [0:65535];
  logic core_we;
  logic [7:0] core_wdata, core_q;
  // dma busy synchroniser
  logic dma_s1, dma_s2, dma_s3, dma_level, next_dma_level;
  // decode helpers
  cmd_t cmd;
  logic in_data, hit_cmd, hit_high, hit_low, hit_holder, hit_flags, hit_status, hit_file;
  logic cyc_active, stall, do_access, start;
  logic [7:0] fval, routed;

  assign core_q = core[cyc_addr];

  always_comb
  begin
    next_dma_level = dma_level;
    // a change counts only once the second and third stages agree
    if (dma_s2 == dma_s3)
    begin
      next_dma_level = dma_s3;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dma_s1 <= 1'b0;
      dma_s2 <= 1'b0;
      dma_s3 <= 1'b0;
      dma_level <= 1'b0;
    end
    else
    begin
      dma_s1 <= dma_busy;
      dma_s2 <= dma_s1;
      dma_s3 <= dma_s2;
      dma_level <= next_dma_level;
    end
  end

  always_comb
  begin
    cmd = cmd_t'(hwdata[15:0]);
    in_data = (bus_state == BUS_DATA);
    hit_cmd = req.upper_zero && (req.offset == OFS_COMMAND);
    hit_high = req.upper_zero && (req.offset == OFS_ADDR_HIGH);
    hit_low = req.upper_zero && (req.offset == OFS_ADDR_LOW);
    hit_holder = req.upper_zero && (req.offset == OFS_HOLDER);
    hit_flags = req.upper_zero && (req.offset == OFS_FLAGS);
    hit_status = req.upper_zero && (req.offset == OFS_STATUS);
    hit_file = req.upper_zero && (req.offset[7:6] == FILE_WINDOW) && (req.offset[1:0] == 2'h0);
    cyc_active = (cnt != CNT_IDLE);
    last_cnt = cyc_half ? HALF_LAST : FULL_LAST;
    // a stalled access is simply not performed; only the running cycle and the dma synchroniser move meanwhile
    stall = (req.write && hit_cmd && (cyc_active || dma_level)) // RULE15
      || (req.write && (hit_high || hit_low) && cyc_active) // RULE16
      || (hit_holder && cyc_active && !cyc_write && (cnt <= LOAD_CNT)); // RULE17
    do_access = in_data && !stall; // RULE21
    start = do_access && req.write && hit_cmd; // RULE1
    fval = files[cmd.file];
    // file zero is the microprogram's problem; it is routed like any other
    case (cmd.mode) // RULE8
      MODE_PASS: routed = fval;
      MODE_DEC: routed = ((cmd.dest == DEST_HIGH) && carry_flag) ? fval : fval - 8'h01; // RULE9
      MODE_LINK: routed = fval + {7'h00, carry_flag}; // RULE10
      default: routed = fval + 8'h01;
    endcase
  end

  always_comb
  begin
    next_bus_state = bus_state;
    next_req = req;
    next_hreadyout = hreadyout;
    next_hrdata = hrdata;
    if (bus_state == BUS_IDLE)
    begin
      if (hsel && htrans[1] && hready)
      begin
        next_req.offset = haddr[7:0];
        next_req.upper_zero = (haddr[31:8] == 24'h000000);
        next_req.write = hwrite;
        next_hreadyout = 1'b0;
        next_bus_state = BUS_DATA;
      end
    end
    else if (do_access)
    begin
      next_hreadyout = 1'b1;
      next_bus_state = BUS_IDLE;
      next_hrdata = WORD_RESET;
      if (!req.write)
      begin
        if (hit_high)
        begin
          next_hrdata[7:0] = addr_high;
        end
        else if (hit_low)
        begin
          next_hrdata[7:0] = addr_low;
        end
        else if (hit_holder)
        begin
          next_hrdata[7:0] = holder;
        end
        else if (hit_flags)
        begin
          next_hrdata[FLAG_CARRY] = carry_flag;
          next_hrdata[FLAG_COND_LSB +: 3] = cond_flags;
        end
        else if (hit_status)
        begin
          next_hrdata[STAT_BUSY] = cyc_active;
          next_hrdata[STAT_CNT_LSB +: 3] = cnt;
          next_hrdata[STAT_WRITE] = cyc_write;
          next_hrdata[STAT_HALF] = cyc_half;
          next_hrdata[STAT_DMA] = dma_level;
        end
        else if (hit_file)
        begin
          next_hrdata[7:0] = files[req.offset[5:2]];
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_state <= BUS_IDLE;
      req <= '0;
      hreadyout <= 1'b1;
      hrdata <= WORD_RESET;
      hresp <= 1'b0;
    end
    else
    begin
      bus_state <= next_bus_state;
      req <= next_req;
      hreadyout <= next_hreadyout;
      hrdata <= next_hrdata;
      hresp <= 1'b0;
    end
  end

  always_comb
  begin
    next_addr_high = addr_high;
    next_addr_low = addr_low;
    next_holder = holder;
    next_carry_flag = carry_flag;
    next_cond_flags = cond_flags;
    file_we = 1'b0;
    file_idx = req.offset[5:2];
    file_wdata = hwdata[7:0];
    if (do_access && req.write)
    begin
      if (hit_high)
      begin
        next_addr_high = hwdata[7:0];
      end
      else if (hit_low)
      begin
        next_addr_low = hwdata[7:0];
      end
      else if (hit_holder)
      begin
        // no interlock on write cycles: changing it early corrupts the store
        next_holder = hwdata[7:0];
      end
      else if (hit_flags)
      begin
        next_carry_flag = hwdata[FLAG_CARRY];
        next_cond_flags = hwdata[FLAG_COND_LSB +: 3];
      end
      else if (hit_file)
      begin
        file_we = 1'b1;
      end
    end
    // flags and carry deliberately untouched by a memory command
    if (start) // RULE14
    begin
      if (!cmd.write)
      begin
        next_holder = BYTE_RESET; // RULE11
      end
      if (!cmd.inhibit)
      begin
        file_we = 1'b1;
        file_idx = cmd.file;
        file_wdata = routed;
      end
      // the initiating command may load addr_high, addr_low or the holder without delay
      case (cmd.dest) // RULE16
        DEST_HIGH: next_addr_high = routed;
        DEST_LOW: next_addr_low = routed;
        DEST_HOLDER: next_holder = routed;
        default: next_holder = next_holder;
      endcase
    end
    if (cyc_active && !cyc_write && (cnt == LOAD_CNT))
    begin
      next_holder = core_q; // RULE11
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_high <= BYTE_RESET;
      addr_low <= BYTE_RESET;
      holder <= BYTE_RESET;
      carry_flag <= 1'b0;
      cond_flags <= 3'h0;
    end
    else
    begin
      addr_high <= next_addr_high;
      addr_low <= next_addr_low;
      holder <= next_holder;
      carry_flag <= next_carry_flag;
      cond_flags <= next_cond_flags;
    end
  end

  // file storage has no reset; software initialises what it uses
  always_ff @(posedge hclk)
  begin
    if (file_we)
    begin
      files[file_idx] <= file_wdata;
    end
  end

  always_comb
  begin
    next_cnt = cnt;
    next_cyc_write = cyc_write;
    next_cyc_half = cyc_half;
    next_cyc_addr = cyc_addr;
    core_we = 1'b0;
    core_wdata = core_q;
    if (start)
    begin
      next_cnt = CNT_FIRST;
      next_cyc_write = cmd.write; // RULE4
      next_cyc_half = cmd.half; // RULE3
      // address as it stands on the command clock, before any routed update
      next_cyc_addr = {addr_high, addr_low}; // RULE19
    end
    else if (cyc_active)
    begin
      if (cnt == last_cnt)
      begin
        next_cnt = CNT_IDLE; // RULE5
      end
      else
      begin
        next_cnt = cnt + CNT_FIRST;
      end
      if (cyc_half && (cnt == HALF_LAST))
      begin
        core_we = 1'b1;
        core_wdata = cyc_write ? (core_q & holder) : ALL_ONES; // RULE7
      end
      else if (!cyc_half && cyc_write && (cnt == FULL_LAST))
      begin
        // holder sampled at the last clock of the window, old contents discarded
        core_we = 1'b1;
        core_wdata = holder; // RULE6
      end
    end
    next_mem_busy = (next_cnt != CNT_IDLE); // RULE20
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt <= CNT_IDLE;
      cyc_write <= 1'b0;
      cyc_half <= 1'b0;
      cyc_addr <= 16'h0000;
      mem_busy <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      cyc_write <= next_cyc_write;
      cyc_half <= next_cyc_half;
      cyc_addr <= next_cyc_addr;
      mem_busy <= next_mem_busy;
    end
  end

  // full read leaves core untouched: no write enable on that path
  always_ff @(posedge hclk)
  begin
    if (core_we)
    begin
      core[cyc_addr] <= core_wdata;
    end
  end

endmodule

//--- tb/core_cmd_chk.sv
`timescale 1ns/10ps
module core_cmd_chk
  import core_cmd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic dma_busy,
  input wire logic mem_busy
);
  logic take;
  logic pend;
  logic next_pend;
  assign take = hsel && htrans[1] && hready && hreadyout;
  // remembers whether the transfer in flight writes an address register
  always_comb
  begin
    next_pend = pend;
    if (take)
      next_pend = hwrite && (haddr == {24'h0, OFS_ADDR_HIGH} || haddr == {24'h0, OFS_ADDR_LOW});
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pend <= 1'b0;
    else
      pend <= next_pend;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_take_wait; take |=> !hreadyout; endproperty
  a_take_wait: assert property (p_take_wait) else $error("no wait state after take");
  property p_answer; take |=> ##[1:20] hreadyout; endproperty
  a_answer: assert property (p_answer) else $error("transfer never completed");
  property p_stands; hreadyout && !take |=> hreadyout && $stable(hrdata); endproperty
  a_stands: assert property (p_stands) else $error("idle bus output moved");
  property p_stall_quiet; !hreadyout |-> $stable(hrdata); endproperty
  a_stall_quiet: assert property (p_stall_quiet) else $error("read data moved while stalled");
  property p_busy_min; $fell(mem_busy) |-> $past(mem_busy, 2); endproperty
  a_busy_min: assert property (p_busy_min) else $error("core cycle too short");
  property p_busy_max; $rose(mem_busy) |-> ##[2:4] !mem_busy; endproperty
  a_busy_max: assert property (p_busy_max) else $error("core cycle too long");
  property p_dma_hold; dma_busy [*6] |-> !$rose(mem_busy); endproperty
  a_dma_hold: assert property (p_dma_hold) else $error("cycle started during dma");
  property p_addr_stall; $rose(hreadyout) && pend |-> !mem_busy; endproperty
  a_addr_stall: assert property (p_addr_stall) else $error("address changed mid cycle");
endmodule
bind core_cmd_exec core_cmd_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .dma_busy(dma_busy), .mem_busy(mem_busy));

//--- tb/core_dma_model.sv
`timescale 1ns/10ps
module core_dma_model
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic [3:0] len,
  output logic dma_busy
);
  logic [3:0] left;
  // a contending transfer owns the memory for len clocks, the block has to wait it out
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      left <= 4'h0;
    else if (start)
      left <= len;
    else if (left != 4'h0)
      left <= left - 4'h1;
  end
  assign dma_busy = (left != 4'h0);
endmodule

//--- tb/test_core_memory_cycle_command.sv
`timescale 1ns/10ps
module test_core_memory_cycle_command;
  import core_cmd_pkg::*;
  localparam logic [31:0] reg_cmd = {24'h0, OFS_COMMAND};
  localparam logic [31:0] reg_high = {24'h0, OFS_ADDR_HIGH};
  localparam logic [31:0] reg_low = {24'h0, OFS_ADDR_LOW};
  localparam logic [31:0] reg_hold = {24'h0, OFS_HOLDER};
  localparam logic [31:0] reg_flags = {24'h0, OFS_FLAGS};
  localparam logic [31:0] reg_stat = {24'h0, OFS_STATUS};
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, dma_busy, mem_busy, dma_start, pend_rd, c;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, m;
  logic [3:0] dma_len;
  logic [7:0] seed, v, e;
  logic [63:0] note;
  logic [63:0] notes[$];
  int num_errors;
  int samples_checked;

  core_cmd_exec u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .dma_busy(dma_busy), .mem_busy(mem_busy));
  core_dma_model u_dma (.hclk(hclk), .hresetn(hresetn), .start(dma_start), .len(dma_len), .dma_busy(dma_busy));

  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [31:0] cmdw(input logic [3:0] f, input logic [1:0] md, input logic h, input logic w,
    input logic i, input logic [1:0] d);
    return {20'h0, f, md, h, w, i, 1'b0, d};
  endfunction

  function automatic logic [31:0] fa(input logic [3:0] i);
    return {24'h0, FILE_WINDOW, i, 2'b00};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      num_errors++;
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1)
      num_errors++;
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] x);
    notes.push_back({a, x});
    xfer(1'b0, a, 32'h0);
  endtask

  // completion is judged from the bus, independent of the driver's own wait
  always @(posedge hclk)
  begin
    if (pend_rd && hreadyout === 1'b1 && notes.size() > 0)
    begin
      pend_rd = 1'b0;
      note = notes.pop_front();
      check($sformatf("rd %h", note[63:32]), hrdata, note[31:0]);
      check("hresp", {31'h0, hresp}, 32'h0);
    end
    if (hsel && htrans[1] && hreadyout && !hwrite)
      pend_rd = 1'b1;
  end

  initial
  begin
    #20000;
    num_errors++;
    finish_test();
  end

  initial
  begin
    {hresetn, hsel, hwrite, dma_start, pend_rd} = 5'h0;
    {haddr, hwdata, htrans} = 66'h0;
    dma_len = 4'h8;
    seed = 8'h13;
    num_errors = 0;
    samples_checked = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b1, reg_high, 32'h12);
    xfer(1'b1, reg_low, 32'h34);
    xfer(1'b1, reg_hold, 32'ha5);
    xfer(1'b1, reg_cmd, cmdw(4'h1, MODE_PASS, 1'b0, 1'b1, 1'b1, DEST_NONE));
    rd(reg_stat, {25'h0, 1'b0, 1'b0, 1'b1, FULL_LAST, 1'b1});
    repeat (5) @(posedge hclk);
    xfer(1'b1, reg_cmd, cmdw(4'h1, MODE_PASS, 1'b0, 1'b0, 1'b1, DEST_NONE));
    xfer(1'b1, reg_low, 32'h34);
    rd(reg_hold, 32'ha5);
    xfer(1'b1, reg_hold, 32'h00);
    xfer(1'b1, reg_cmd, cmdw(4'h1, MODE_PASS, 1'b0, 1'b0, 1'b1, DEST_NONE));
    rd(reg_hold, 32'ha5);
    xfer(1'b1, reg_low, 32'h35);
    xfer(1'b1, reg_hold, 32'h3c);
    xfer(1'b1, reg_cmd, cmdw(4'h1, MODE_PASS, 1'b0, 1'b1, 1'b1, DEST_NONE));
    repeat (5) @(posedge hclk);
    xfer(1'b1, reg_cmd, cmdw(4'h1, MODE_PASS, 1'b1, 1'b0, 1'b1, DEST_NONE));
    rd(reg_hold, 32'h3c);
    xfer(1'b1, reg_cmd, cmdw(4'h1, MODE_PASS, 1'b1, 1'b0, 1'b1, DEST_NONE));
    rd(reg_hold, 32'hff);
    xfer(1'b1, reg_hold, 32'h5a);
    xfer(1'b1, reg_cmd, cmdw(4'h1, MODE_PASS, 1'b1, 1'b1, 1'b1, DEST_NONE));
    repeat (3) @(posedge hclk);
    xfer(1'b1, reg_hold, 32'h0f);
    xfer(1'b1, reg_cmd, cmdw(4'h1, MODE_PASS, 1'b1, 1'b1, 1'b1, DEST_NONE));
    repeat (3) @(posedge hclk);
    xfer(1'b1, reg_cmd, cmdw(4'h1, MODE_PASS, 1'b0, 1'b0, 1'b1, DEST_NONE));
    rd(reg_hold, 32'h0a);
    for (int k = 0; k < 8; k++)
    begin
      v = seed;
      seed = lfsr(seed);
      c = k[0];
      m = k[2:1];
      e = (m == 2'b00) ? v : (m == 2'b01) ? v - 8'h1 : (m == 2'b10) ? v + {7'h0, c} : v + 8'h1;
      xfer(1'b1, reg_flags, {28'h0, 3'b101, c});
      xfer(1'b1, fa(4'h2), {24'h0, v});
      xfer(1'b1, reg_cmd, cmdw(4'h2, m, 1'b0, 1'b0, 1'b0, DEST_NONE));
      rd(fa(4'h2), {24'h0, e});
      rd(reg_flags, {28'h0, 3'b101, c});
    end
    xfer(1'b1, fa(4'h3), 32'h80);
    dma_start <= 1'b1;
    @(posedge hclk);
    dma_start <= 1'b0;
    // give the synchroniser time, so the command really meets a busy memory
    repeat (3) @(posedge hclk);
    xfer(1'b1, reg_cmd, cmdw(4'h3, MODE_DEC, 1'b0, 1'b0, 1'b1, DEST_HIGH));
    rd(reg_high, 32'h80);
    rd(fa(4'h3), 32'h80);
    xfer(1'b1, reg_flags, 32'h0);
    xfer(1'b1, reg_cmd, cmdw(4'h3, MODE_DEC, 1'b0, 1'b0, 1'b1, DEST_HIGH));
    rd(reg_high, 32'h7f);
    repeat (5) @(posedge hclk);
    finish_test();
  end
endmodule
